// ### logic/pic_regs.svh
// register map, field positions, reset values and counts of the port interrupt block
// assumes byte-wide registers reached by an 8-bit address
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// register offsets
`define PIC_ADDR_P0_FLAGS 8'h89
`define PIC_ADDR_P1_FLAGS 8'h8A
`define PIC_ADDR_P2_FLAGS 8'h8B
`define PIC_ADDR_CTL 8'h8C
`define PIC_ADDR_P1_MASK 8'h8D
`define PIC_ADDR_STAT 8'hA0
`define PIC_ADDR_CLR 8'hA1
`define PIC_ADDR_IEN 8'hA2

// control register fields
`define PIC_CTL_P0_EDGE 0
`define PIC_CTL_P1_EDGE 1
`define PIC_CTL_P2_EDGE 2
`define PIC_CTL_P0L_IEN 3
`define PIC_CTL_P0H_IEN 4
`define PIC_CTL_P2_IEN 5
`define PIC_CTL_SPARE 6
`define PIC_CTL_UNUSED 7

// write masks and reset values
`define PIC_CTL_WMASK 8'h7F
`define PIC_IEN_WMASK 8'h07
`define PIC_CTL_RESET 8'h00
`define PIC_FLAGS_RESET 8'h00
`define PIC_MASK_RESET 8'h00
`define PIC_STAT_RESET 8'h00
`define PIC_IEN_RESET 8'h00

// status bits, one per port
`define PIC_STAT_P0 0
`define PIC_STAT_P1 1
`define PIC_STAT_P2 2

// cycles from reset release until edge detection is trusted
`define PIC_WARM_CYCLES 2'h3

`endif

// ### logic/pic_pkg.sv
// types shared by the port interrupt block
// assumes nothing beyond a SystemVerilog compiler
package pic_pkg;

   typedef logic [7:0] pic_byte_t;
   typedef logic [2:0] pic_ports_t;

endpackage

// ### logic/pic_edge_detect.sv
// pin synchroniser and selectable rising or falling edge detector
// assumes asynchronous pins and a sense select from the mclk domain
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_edge_detect #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // pins and sense
   input wire logic [WIDTH-1:0] pins,
   input wire logic falling,
   // results
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] edge_hit,
   output logic armed
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] prev_r;
   logic [1:0] warm_r;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] fall;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
         warm_r <= 2'h0;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
         prev_r <= sync_r;
         warm_r <= armed ? warm_r : warm_r + 2'h1;
      end
   end

   // a pin high at reset would look like a rise before the pipe fills
   assign armed = (warm_r == `PIC_WARM_CYCLES);
   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
   assign edge_hit = armed ? (falling ? fall : rise) : '0;

endmodule

// ### logic/pic_port_irq.sv
// port pin-change interrupt control with per-pin pending flags
// assumes a one-clock register port with read data one cycle later
//
// Functional notes
// - port 2 pins 0-4 requests pass only while control bit 5 is set.
// - port 0 pins 4-7 requests pass only while control bit 4 is set.
// - port 0 pins 0-3 requests pass only while control bit 3 is set.
// - control bit 2 picks rising (0) or falling (1) edge for port 2.
// - control bit 1 picks rising (0) or falling (1) edge for port 1.
// - control bit 0 picks rising (0) or falling (1) edge for port 0.
// - all control bits reset to 0: interrupts off, rising edge.
// - one pending flag per pin, set by its edge, cleared by writing 0.
// - port 1 requests are also gated per pin by an eight-bit mask.
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_port_irq (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // port pins
   input wire logic [7:0] p0_pins,
   input wire logic [7:0] p1_pins,
   input wire logic [4:0] p2_pins,
   // interrupt outputs
   output logic [2:0] port_req,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   pic_pkg::pic_byte_t ctl_r;
   pic_pkg::pic_byte_t ctl_nxt;
   pic_pkg::pic_byte_t p0_pend_r;
   pic_pkg::pic_byte_t p0_pend_nxt;
   pic_pkg::pic_byte_t p1_pend_r;
   pic_pkg::pic_byte_t p1_pend_nxt;
   pic_pkg::pic_byte_t p2_pend_r;
   pic_pkg::pic_byte_t p2_pend_nxt;
   pic_pkg::pic_byte_t p1_mask_r;
   pic_pkg::pic_byte_t p1_mask_nxt;
   pic_pkg::pic_byte_t stat_r;
   pic_pkg::pic_byte_t stat_nxt;
   pic_pkg::pic_byte_t ien_r;
   pic_pkg::pic_byte_t ien_nxt;
   pic_pkg::pic_byte_t rd_data_r;
   pic_pkg::pic_byte_t rd_data_nxt;
   pic_pkg::pic_ports_t port_req_r;
   pic_pkg::pic_ports_t port_req_nxt;
   logic irq_r;
   logic irq_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // set wins over clear so an edge in the clearing cycle is kept
   function automatic pic_pkg::pic_byte_t pic_sticky(
      input pic_pkg::pic_byte_t flags,
      input pic_pkg::pic_byte_t hits,
      input pic_pkg::pic_byte_t clr
   );
      pic_sticky = (flags & ~clr) | hits;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   logic hit_ctl;
   logic hit_p0f;
   logic hit_p1f;
   logic hit_p2f;
   logic hit_mask;
   logic hit_stat;
   logic hit_clr;
   logic hit_ien;
   logic wr_ctl;
   logic wr_p0f;
   logic wr_p1f;
   logic wr_p2f;
   logic wr_mask;
   logic wr_clr;
   logic wr_ien;

   assign hit_ctl = (addr == `PIC_ADDR_CTL);
   assign hit_p0f = (addr == `PIC_ADDR_P0_FLAGS);
   assign hit_p1f = (addr == `PIC_ADDR_P1_FLAGS);
   assign hit_p2f = (addr == `PIC_ADDR_P2_FLAGS);
   assign hit_mask = (addr == `PIC_ADDR_P1_MASK);
   assign hit_stat = (addr == `PIC_ADDR_STAT);
   assign hit_clr = (addr == `PIC_ADDR_CLR);
   assign hit_ien = (addr == `PIC_ADDR_IEN);

   assign wr_ctl = wr_en && hit_ctl;
   assign wr_p0f = wr_en && hit_p0f;
   assign wr_p1f = wr_en && hit_p1f;
   assign wr_p2f = wr_en && hit_p2f;
   assign wr_mask = wr_en && hit_mask;
   assign wr_clr = wr_en && hit_clr;
   assign wr_ien = wr_en && hit_ien;

   ////////////////////////////////////////////////////////////////////////////
   // control fields

   logic p0_falling;
   logic p1_falling;
   logic p2_falling;
   logic p0l_on;
   logic p0h_on;
   logic p2_on;

   assign p0_falling = ctl_r[`PIC_CTL_P0_EDGE];
   assign p1_falling = ctl_r[`PIC_CTL_P1_EDGE];
   assign p2_falling = ctl_r[`PIC_CTL_P2_EDGE];
   assign p0l_on = ctl_r[`PIC_CTL_P0L_IEN];
   assign p0h_on = ctl_r[`PIC_CTL_P0H_IEN];
   assign p2_on = ctl_r[`PIC_CTL_P2_IEN];

   // bit 7 is never stored, bit 6 is plain storage
   assign ctl_nxt = wr_ctl ? (wr_data & `PIC_CTL_WMASK) : ctl_r;

   ////////////////////////////////////////////////////////////////////////////
   // edge detection

   logic [7:0] p0_lvl;
   logic [7:0] p1_lvl;
   logic [4:0] p2_lvl;
   logic [7:0] p0_hit;
   logic [7:0] p1_hit;
   logic [4:0] p2_hit;
   logic p0_armed;
   logic p1_armed;
   logic p2_armed;

   pic_edge_detect #(.WIDTH(8)) u_p0_edge (
      .mclk(mclk),
      .rst_n(rst_n),
      .pins(p0_pins),
      .falling(p0_falling),
      .level(p0_lvl),
      .edge_hit(p0_hit),
      .armed(p0_armed)
   );

   pic_edge_detect #(.WIDTH(8)) u_p1_edge (
      .mclk(mclk),
      .rst_n(rst_n),
      .pins(p1_pins),
      .falling(p1_falling),
      .level(p1_lvl),
      .edge_hit(p1_hit),
      .armed(p1_armed)
   );

   pic_edge_detect #(.WIDTH(5)) u_p2_edge (
      .mclk(mclk),
      .rst_n(rst_n),
      .pins(p2_pins),
      .falling(p2_falling),
      .level(p2_lvl),
      .edge_hit(p2_hit),
      .armed(p2_armed)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pending flags: writing 0 clears, writing 1 leaves the flag alone

   pic_pkg::pic_byte_t p0_clr;
   pic_pkg::pic_byte_t p1_clr;
   pic_pkg::pic_byte_t p2_clr;
   pic_pkg::pic_byte_t p2_hit_w;

   assign p0_clr = wr_p0f ? ~wr_data : 8'h00;
   assign p1_clr = wr_p1f ? ~wr_data : 8'h00;
   assign p2_clr = wr_p2f ? ~wr_data : 8'h00;
   assign p2_hit_w = {3'h0, p2_hit};

   assign p0_pend_nxt = pic_sticky(p0_pend_r, p0_hit, p0_clr);
   assign p1_pend_nxt = pic_sticky(p1_pend_r, p1_hit, p1_clr);
   assign p2_pend_nxt = pic_sticky(p2_pend_r, p2_hit_w, p2_clr);

   assign p1_mask_nxt = wr_mask ? wr_data : p1_mask_r;

   ////////////////////////////////////////////////////////////////////////////
   // request gating

   pic_pkg::pic_byte_t p0_gate;
   pic_pkg::pic_byte_t p2_gate;
   pic_pkg::pic_byte_t p0_fwd;
   pic_pkg::pic_byte_t p1_fwd;
   pic_pkg::pic_byte_t p2_fwd;
   pic_pkg::pic_ports_t port_evt;

   assign p0_gate = {{4{p0h_on}}, {4{p0l_on}}};
   assign p2_gate = {8{p2_on}};
   assign p0_fwd = p0_pend_r & p0_gate;
   assign p1_fwd = p1_pend_r & p1_mask_r;
   assign p2_fwd = p2_pend_r & p2_gate;
   assign port_req_nxt = {|p2_fwd, |p1_fwd, |p0_fwd};

   // a status event is a fresh edge that passes the gate
   assign port_evt[`PIC_STAT_P0] = |(p0_hit & p0_gate);
   assign port_evt[`PIC_STAT_P1] = |(p1_hit & p1_mask_r);
   assign port_evt[`PIC_STAT_P2] = |(p2_hit_w & p2_gate);

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, clear and enable

   pic_pkg::pic_byte_t stat_clr;

   assign stat_clr = wr_clr ? wr_data : 8'h00;
   assign stat_nxt = pic_sticky(stat_r, {5'h0, port_evt}, stat_clr);
   assign ien_nxt = wr_ien ? (wr_data & `PIC_IEN_WMASK) : ien_r;
   assign irq_nxt = |(stat_r & ien_r);

   ////////////////////////////////////////////////////////////////////////////
   // read path; the clear register reads as zero

   pic_pkg::pic_byte_t rd_mux;

   assign rd_mux = hit_ctl ? ctl_r :
      hit_p0f ? p0_pend_r :
      hit_p1f ? p1_pend_r :
      hit_p2f ? p2_pend_r :
      hit_mask ? p1_mask_r :
      hit_stat ? stat_r :
      hit_ien ? ien_r : 8'h00;
   assign rd_data_nxt = rd_en ? rd_mux : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r <= `PIC_CTL_RESET;
         p1_mask_r <= `PIC_MASK_RESET;
         ien_r <= `PIC_IEN_RESET;
      end else begin
         ctl_r <= ctl_nxt;
         p1_mask_r <= p1_mask_nxt;
         ien_r <= ien_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         p0_pend_r <= `PIC_FLAGS_RESET;
         p1_pend_r <= `PIC_FLAGS_RESET;
         p2_pend_r <= `PIC_FLAGS_RESET;
         stat_r <= `PIC_STAT_RESET;
      end else begin
         p0_pend_r <= p0_pend_nxt;
         p1_pend_r <= p1_pend_nxt;
         p2_pend_r <= p2_pend_nxt;
         stat_r <= stat_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= 8'h00;
         port_req_r <= 3'h0;
         irq_r <= 1'h0;
      end else begin
         rd_data_r <= rd_data_nxt;
         port_req_r <= port_req_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign rd_data = rd_data_r;
   assign port_req = port_req_r;
   assign irq = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic first_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         first_r <= 1'h1;
      end else begin
         first_r <= 1'h0;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_p2_gate_off: assert property (
      !p2_on |=> !port_req_r[2]
   ) else $error("port 2 request passed while disabled");

   a_p0_high_gate: assert property (
      !p0h_on && p0_pend_r[3:0] == 4'h0 |=> !port_req_r[0]
   ) else $error("port 0 upper nibble request passed while disabled");

   a_p0_low_gate: assert property (
      !p0l_on && p0_pend_r[7:4] == 4'h0 |=> !port_req_r[0]
   ) else $error("port 0 lower nibble request passed while disabled");

   a_p2_edge_sense: assert property (
      p2_armed && $past(p2_armed) && (p2_lvl[0] != $past(p2_lvl[0]))
         && (p2_lvl[0] == !p2_falling)
      |=> p2_pend_r[0]
   ) else $error("port 2 edge of selected sense not flagged");

   a_p1_edge_sense: assert property (
      p1_armed && $past(p1_armed) && (p1_lvl[0] != $past(p1_lvl[0]))
      |-> p1_hit[0] == (p1_lvl[0] == !p1_falling)
   ) else $error("port 1 edge sense wrong");

   a_p0_edge_sense: assert property (
      p0_armed && $past(p0_armed) && (p0_lvl[7] != $past(p0_lvl[7]))
      |-> p0_hit[7] == (p0_lvl[7] == !p0_falling)
   ) else $error("port 0 edge sense wrong");

   a_ctl_after_reset: assert property (
      first_r |-> ctl_r == `PIC_CTL_RESET && port_req_r == 3'h0
   ) else $error("control not cleared by reset");

   a_flag_sticky: assert property (
      p1_pend_r[3] && !(wr_p1f && !wr_data[3]) |=> p1_pend_r[3]
   ) else $error("pending flag lost without a zero write");

   a_flag_set_wins: assert property (
      p0_hit[2] && wr_p0f |=> p0_pend_r[2]
   ) else $error("edge lost in clearing cycle");

   a_p1_pin_mask: assert property (
      (p1_pend_r & p1_mask_r) == 8'h00 |=> !port_req_r[1]
   ) else $error("masked port 1 pin raised a request");

   a_ctl_top_bits: assert property (
      wr_ctl |=> !ctl_r[`PIC_CTL_UNUSED]
         && ctl_r[`PIC_CTL_SPARE] == $past(wr_data[`PIC_CTL_SPARE])
   ) else $error("control bit 7 or 6 misbehaves");

   a_irq_follows: assert property (
      (stat_r & ien_r) != 8'h00 |=> irq_r
   ) else $error("interrupt output does not follow status");

   a_irq_quiet: assert property (
      (stat_r & ien_r) == 8'h00 |=> !irq_r
   ) else $error("interrupt output high with no enabled status");

   a_read_window: assert property (
      !rd_en |=> rd_data_r == 8'h00
   ) else $error("read data outside its cycle");

   c_p0_request: cover property (p0l_on && p0_hit[0] ##1 1'b1 ##1 port_req_r[0]);
   c_p1_falling: cover property (p1_falling && p1_hit[5]);
   c_p2_irq: cover property (p2_on && ien_r[`PIC_STAT_P2] ##[1:4] irq_r);
   c_clear_flag: cover property (p0_pend_r[1] && wr_p0f && !wr_data[1]);

endmodule

// ### dv/pic_pin_model.sv
// pin-side partner: drives the three port pin groups toward the block
// assumes callers enter its tasks from the bench and mclk is running
`timescale 1ns/1ps

module pic_pin_model (
   // clock
   input wire logic mclk,
   // pins toward the block
   output logic [7:0] p0_pins,
   output logic [7:0] p1_pins,
   output logic [4:0] p2_pins
);
   initial begin
      p0_pins = 8'h00;
      p1_pins = 8'h00;
      p2_pins = 5'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pins are pushed levels; no resume source on port 0 pin 7 here
   // so the falling sense on port 0 is free to use
   task automatic set_pin(input logic [1:0] port, input logic [2:0] pin, input logic lvl);
      @(posedge mclk);
      case (port)
         2'h0: p0_pins[pin] <= lvl;
         2'h1: p1_pins[pin] <= lvl;
         default: p2_pins[pin] <= lvl;
      endcase
   endtask

   task automatic all_low();
      @(posedge mclk);
      p0_pins <= 8'h00;
      p1_pins <= 8'h00;
      p2_pins <= 5'h00;
   endtask
endmodule

// ### dv/pic_port_irq_test.sv
// self-checking bench for the port interrupt block
// assumes the pin model beside it and the register map header
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_port_irq_test;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] mask;
      logic [1:0] port;
      logic [2:0] pin;
      logic fin;
      logic hit;
      logic req;
   } pic_case_s;

   logic mclk, rst_n, wr_en, rd_en, irq;
   logic [7:0] addr, wr_data, rd_data, p0_pins, p1_pins, rd;
   logic [4:0] p2_pins;
   logic [2:0] port_req;
   int miscompares, check_count, cycles;
   pic_case_s cases[$];

   pic_port_irq u_pic_port_irq (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .p0_pins(p0_pins), .p1_pins(p1_pins),
      .p2_pins(p2_pins), .port_req(port_req), .irq(irq));
   pic_pin_model u_pic_pin_model (.mclk(mclk), .p0_pins(p0_pins), .p1_pins(p1_pins),
      .p2_pins(p2_pins));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // run is about 520 cycles; ceiling leaves margin
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   task automatic clear_all();
      reg_wr(`PIC_ADDR_P0_FLAGS, 8'h00);
      reg_wr(`PIC_ADDR_P1_FLAGS, 8'h00);
      reg_wr(`PIC_ADDR_P2_FLAGS, 8'h00);
      reg_wr(`PIC_ADDR_CLR, 8'h07);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic add(input logic [7:0] c, input logic [7:0] m, input logic [1:0] p,
                      input logic [2:0] n, input logic f, input logic h, input logic r);
      cases.push_back({c, m, p, n, f, h, r});
   endtask

   // edge on one pin, from a cleared state, under the row's control and mask
   task automatic run_case(input pic_case_s c);
      reg_wr(`PIC_ADDR_CTL, c.ctl);
      reg_wr(`PIC_ADDR_P1_MASK, c.mask);
      u_pic_pin_model.all_low();
      u_pic_pin_model.set_pin(c.port, c.pin, ~c.fin);
      repeat (6) @(posedge mclk);
      clear_all();
      u_pic_pin_model.set_pin(c.port, c.pin, c.fin);
      repeat (6) @(posedge mclk);
      reg_rd(`PIC_ADDR_P0_FLAGS + {6'h00, c.port}, rd);
      check_byte("flags", c.hit ? (8'h01 << c.pin) : 8'h00, rd);
      check_bit("port_req", c.req, port_req[c.port]);
      check_bit("irq", c.req, irq);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      reg_rd(`PIC_ADDR_CTL, rd);
      check_byte("ctl reset", 8'h00, rd);
      check_byte("req reset", 8'h00, {4'h0, port_req, irq});
      reg_wr(`PIC_ADDR_IEN, 8'h07);
      add(8'h08, 8'h00, 2'h0, 3'h0, 1'h1, 1'h1, 1'h1);
      add(8'h00, 8'h00, 2'h0, 3'h1, 1'h1, 1'h1, 1'h0);
      add(8'h10, 8'h00, 2'h0, 3'h5, 1'h1, 1'h1, 1'h1);
      add(8'h08, 8'h00, 2'h0, 3'h7, 1'h1, 1'h1, 1'h0);
      add(8'h09, 8'h00, 2'h0, 3'h2, 1'h0, 1'h1, 1'h1);
      add(8'h08, 8'h00, 2'h0, 3'h3, 1'h0, 1'h0, 1'h0);
      add(8'h20, 8'h00, 2'h2, 3'h4, 1'h1, 1'h1, 1'h1);
      add(8'h18, 8'h00, 2'h2, 3'h0, 1'h1, 1'h1, 1'h0);
      add(8'h24, 8'h00, 2'h2, 3'h1, 1'h0, 1'h1, 1'h1);
      add(8'h20, 8'h00, 2'h2, 3'h2, 1'h0, 1'h0, 1'h0);
      add(8'h38, 8'h01, 2'h1, 3'h0, 1'h1, 1'h1, 1'h1);
      add(8'h38, 8'hF7, 2'h1, 3'h3, 1'h1, 1'h1, 1'h0);
      add(8'h02, 8'h80, 2'h1, 3'h7, 1'h0, 1'h1, 1'h1);
      add(8'h00, 8'hFF, 2'h1, 3'h6, 1'h0, 1'h0, 1'h0);
      foreach (cases[i]) run_case(cases[i]);
      reg_wr(`PIC_ADDR_CTL, 8'hFF);
      reg_rd(`PIC_ADDR_CTL, rd);
      check_byte("ctl spare", 8'h7F, rd);
      // pending flag survives a one-write and a disable, reappears on enable
      run_case({8'h08, 8'h00, 2'h0, 3'h0, 1'h1, 1'h1, 1'h1});
      reg_wr(`PIC_ADDR_P0_FLAGS, 8'hFF);
      reg_rd(`PIC_ADDR_P0_FLAGS, rd);
      check_byte("flag one write", 8'h01, rd);
      reg_wr(`PIC_ADDR_CTL, 8'h40);
      settle();
      check_bit("req off", 1'b0, port_req[0]);
      reg_wr(`PIC_ADDR_CTL, 8'h08);
      settle();
      check_bit("req back", 1'b1, port_req[0]);
      reg_wr(`PIC_ADDR_IEN, 8'h00);
      settle();
      check_bit("irq masked", 1'b0, irq);
      reg_rd(`PIC_ADDR_STAT, rd);
      check_byte("status", 8'h01, rd);
      reg_wr(`PIC_ADDR_IEN, 8'h01);
      settle();
      check_bit("irq enabled", 1'b1, irq);
      reg_wr(`PIC_ADDR_CLR, 8'h01);
      settle();
      check_bit("irq cleared", 1'b0, irq);
      reg_wr(`PIC_ADDR_P0_FLAGS, 8'hFE);
      reg_rd(`PIC_ADDR_P0_FLAGS, rd);
      check_byte("flag zero write", 8'h00, rd);
      // edge and zero write meet in one cycle: the edge is kept
      u_pic_pin_model.set_pin(2'h0, 3'h2, 1'b1);
      @(posedge mclk);
      reg_wr(`PIC_ADDR_P0_FLAGS, 8'h00);
      reg_rd(`PIC_ADDR_P0_FLAGS, rd);
      check_byte("flag set wins", 8'h04, rd);
      reg_wr(8'h55, 8'hAA);
      reg_rd(8'h55, rd);
      check_byte("unmapped", 8'h00, rd);
      // second reset in mid-run must bring control back to zero
      reg_wr(`PIC_ADDR_CTL, 8'h3F);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      reg_rd(`PIC_ADDR_CTL, rd);
      check_byte("ctl rereset", 8'h00, rd);
      // pins left high through reset must not look like fresh edges
      repeat (6) @(posedge mclk);
      reg_rd(`PIC_ADDR_P0_FLAGS, rd);
      check_byte("flags rereset", 8'h00, rd);
      report_and_stop();
   end
endmodule
